// [hdl/dsp_slice_cfg.svh]
// register offsets, field positions and reset values of the slice
`ifndef DSP_SLICE_CFG_SVH
`define DSP_SLICE_CFG_SVH

// byte offsets on the register bus
`define OFS_STAGE_SEL   5'h00
`define OFS_MODE        5'h04
`define OFS_IRQ_STATUS  5'h08
`define OFS_IRQ_MASK    5'h0C
`define OFS_ACC_LO      5'h10
`define OFS_ACC_HI      5'h14

// stage select field: six bits per stage, clock/enable/reset pairs
`define STAGE_FIELD_W   6
`define STAGE_SEL_W     18
`define STAGE_SEL_RST   18'h00000

// mode register bit positions
`define MODE_DYN_SIGN   0
`define MODE_SIGNED     1
`define MODE_DYN_SUB    2
`define MODE_SUB        3
`define MODE_W          4
`define MODE_RST        4'h0

// interrupt status bit positions
`define IRQ_OVERFLOW    0
`define IRQ_W           1
`define IRQ_RST         1'h0

`endif

// [hdl/dsp_slice_pkg.sv]
// types shared by the slice control modules
package dsp_slice_pkg;
    typedef logic [1:0] sel_t;

    // candidate choice of one register stage
    typedef struct packed {
        sel_t rst_sel;
        sel_t ce_sel;
        sel_t clk_sel;
    } stage_sel_s;

    typedef enum {STG_INPUT, STG_PIPE, STG_OUTPUT} stage_e;
endpackage

// [hdl/stage_ctl_if.sv]
// carrier between the slice and one stage selector
`timescale 1ns/1ps
`default_nettype none
interface stage_ctl_if;
    logic [3:0]                 clk_tick;  // rising edges of clock candidates
    logic [3:0]                 ce_in;     // enable candidates
    logic [3:0]                 rst_in;    // reset candidates
    dsp_slice_pkg::stage_sel_s  sel;       // chosen candidates
    logic                       step;      // stage loads this cycle
    logic                       clear;     // stage resets this cycle

    modport slice (output clk_tick, ce_in, rst_in, sel,
                   input step, clear);
    modport stage (input clk_tick, ce_in, rst_in, sel,
                   output step, clear);
endinterface
`default_nettype wire

// [hdl/stage_select.sv]
// per-stage choice of clock, enable and reset among four candidates
`timescale 1ns/1ps
`default_nettype none
module stage_select (
    stage_ctl_if.stage ctl  // candidates in, stage strobes out
);
    // pick one of four candidates
    function automatic logic pick(input logic [3:0] v,
                                  input dsp_slice_pkg::sel_t s);
        return v[s];
    endfunction

    // stage advances on its clock edge when its enable is high
    assign ctl.step  = pick(ctl.clk_tick, ctl.sel.clk_sel)
                     & pick(ctl.ce_in, ctl.sel.ce_sel);      // RULE2 RULE3
    // reset acts synchronously on the stage's own clock edge
    assign ctl.clear = pick(ctl.clk_tick, ctl.sel.clk_sel)
                     & pick(ctl.rst_in, ctl.sel.rst_sel);    // RULE3
endmodule // stage_select
`default_nettype wire

// [hdl/dsp_slice_ctl.sv]
// multiply/accumulate slice with stage control and overflow pulse
//
// What the document asks of the block and the fabric
// RULE1: the four clock, enable and reset candidates reach every stage.
// RULE2: each input, pipeline and output stage picks its own clock.
// RULE3: each stage picks its own enable and its own reset among four.
// RULE4: fabric zero-fills narrow unsigned operands up to native width.
// RULE5: fabric sign-extends narrow signed operands up to native width.
// RULE6: unsigned accumulation flags overflow when the sum wraps around.
// RULE7: signed accumulation flags overflow when like signs give unlike.
// RULE8: each overflow shows as a pulse of exactly one clock cycle.
// RULE9: fabric may count overflow pulses to build a wider accumulator.
// RULE10: the output stage always holds the running sum and the flag; the code holds the flag for one REF_CLK cycle only.
// RULE11: with dynamic sign set, signedness may change on any cycle.
// RULE12: with dynamic add/sub set, the operation may change any cycle.
// RULE13: both operands share one signedness and one width.
// RULE14: the overflow pulse comes from the output stage's own strobes.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`include "dsp_slice_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dsp_slice_ctl #(
    parameter int OP_W  = 18,  // native operand width
    parameter int ACC_W = 52   // accumulator width
) (
    input  wire logic             REF_CLK,            // 200 MHz clock
    input  wire logic             RST,                // sync reset, high
    input  wire logic [4:0]       AVS_ADDRESS,        // byte address
    input  wire logic             AVS_READ,           // read request
    input  wire logic             AVS_WRITE,          // write request
    input  wire logic [31:0]      AVS_WRITEDATA,      // write data
    input  wire logic [3:0]       AVS_BYTEENABLE,     // byte lanes
    output logic      [31:0]      AVS_READDATA,       // read data
    output logic                  AVS_WAITREQUEST,    // stall master
    input  wire logic [3:0]       SLICE_CLOCK_CANDIDATES,  // fabric clocks
    input  wire logic [3:0]       SLICE_ENABLE_CANDIDATES, // fabric enables
    input  wire logic [3:0]       SLICE_RESET_CANDIDATES,  // fabric resets
    input  wire logic [OP_W-1:0]  OPERAND_A,          // multiplicand
    input  wire logic [OP_W-1:0]  OPERAND_B,          // multiplier
    input  wire logic             OPERAND_SIGNED,     // dynamic sign
    input  wire logic             ACC_SUBTRACT,       // dynamic add/sub
    output logic      [ACC_W-1:0] ACC_RESULT,         // running sum
    output logic                  OVERFLOW_PULSE,     // wrap pulse
    output logic                  IRQ                 // level interrupt
);
    localparam int BUN_W = 14 + 2 * OP_W;
    localparam int P_W   = 2 * OP_W;

    typedef struct packed {
        logic [BUN_W-1:0]                 sync1;
        logic [BUN_W-1:0]                 sync2;
        logic [3:0]                       clk_prev;
        logic [OP_W-1:0]                  a_q;
        logic [OP_W-1:0]                  b_q;
        logic                             in_signed;
        logic                             in_sub;
        logic [P_W-1:0]                   prod_q;
        logic                             pl_signed;
        logic                             pl_sub;
        logic [ACC_W-1:0]                 acc;
        logic                             ovf;
        logic [`IRQ_W-1:0]                irq_status;
        logic [`IRQ_W-1:0]                irq_mask;
        dsp_slice_pkg::stage_sel_s [2:0]  stage_sel;
        logic [`MODE_W-1:0]               mode;
        logic                             ack;
        logic [31:0]                      rdata;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    stage_ctl_if sc_in ();
    stage_ctl_if sc_pl ();
    stage_ctl_if sc_out ();

    // byte-lane merge of a write into a register
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // zero or sign extension of an operand to double width
    function automatic logic [P_W-1:0] ext(input logic [OP_W-1:0] v,
                                           input logic sgn);
        return {{OP_W{sgn & v[OP_W-1]}}, v};
    endfunction

    // product to sum width, sign kept when signed
    function automatic logic [ACC_W-1:0] widen(input logic [P_W-1:0] p,
                                               input logic sgn);
        if (sgn) begin
            return ACC_W'($signed(p));
        end
        return ACC_W'(p);
    endfunction

    // one accumulate step, carry or borrow in the top bit
    function automatic logic [ACC_W:0] step_sum(input logic [ACC_W-1:0] old,
                                                input logic [ACC_W-1:0] add,
                                                input logic             sub);
        if (sub) begin
            return {1'b0, old} - {1'b0, add};                 // RULE12
        end
        return {1'b0, old} + {1'b0, add};
    endfunction

    // overflow of one accumulate step
    function automatic logic ovf_of(input logic [ACC_W-1:0] old,
                                    input logic [ACC_W-1:0] add,
                                    input logic [ACC_W:0]   res,
                                    input logic             sgn,
                                    input logic             sub);
        logic like;
        logic flip;
        // like signs for an add, unlike signs for a subtract
        like = ((old[ACC_W-1] ^ add[ACC_W-1]) == sub);
        flip = (res[ACC_W-1] != old[ACC_W-1]);
        if (sgn) begin
            return like && flip;                              // RULE7
        end
        return res[ACC_W];                                    // RULE6
    endfunction

    // rising edges of the synchronised candidate clocks
    function automatic logic [3:0] rising(input logic [3:0] now,
                                          input logic [3:0] prev);
        return now & ~prev;
    endfunction

    // synchronised pin bundle, read only through the second stage
    logic [3:0]      clk_now;
    logic [3:0]      ce_now;
    logic [3:0]      rst_now;
    logic [OP_W-1:0] a_now;
    logic [OP_W-1:0] b_now;
    logic            sgn_now;
    logic            sub_now;
    assign {rst_now, ce_now, clk_now, sub_now, sgn_now, b_now, a_now}
        = s_r.sync2;

    // same candidates fan out to every stage selector
    assign sc_in.clk_tick  = rising(clk_now, s_r.clk_prev);  // RULE1
    assign sc_in.ce_in     = ce_now;
    assign sc_in.rst_in    = rst_now;
    assign sc_in.sel       = s_r.stage_sel[dsp_slice_pkg::STG_INPUT];
    assign sc_pl.clk_tick  = rising(clk_now, s_r.clk_prev);  // RULE1
    assign sc_pl.ce_in     = ce_now;
    assign sc_pl.rst_in    = rst_now;
    assign sc_pl.sel       = s_r.stage_sel[dsp_slice_pkg::STG_PIPE];
    assign sc_out.clk_tick = rising(clk_now, s_r.clk_prev);  // RULE1
    assign sc_out.ce_in    = ce_now;
    assign sc_out.rst_in   = rst_now;
    assign sc_out.sel      = s_r.stage_sel[dsp_slice_pkg::STG_OUTPUT];

    stage_select u_sel_in  (.ctl(sc_in));
    stage_select u_sel_pl  (.ctl(sc_pl));
    stage_select u_sel_out (.ctl(sc_out));

    // accumulator arithmetic on the pipeline stage contents
    logic [ACC_W-1:0] addend;
    logic [ACC_W:0]   sum;
    logic             ovf_now;
    always_comb begin
        addend  = widen(s_r.prod_q, s_r.pl_signed);
        sum     = step_sum(s_r.acc, addend, s_r.pl_sub);      // RULE12
        ovf_now = ovf_of(s_r.acc, addend, sum, s_r.pl_signed,
                         s_r.pl_sub);                         // RULE6 RULE7
    end

    // sum fitted to two bus words: zero-filled up to 64 bits, cut to 64 bits if wider

    logic [63:0] acc_view;
    assign acc_view = 64'(s_r.acc);

    // register read decode
    logic [31:0] rd_mux;
    always_comb begin
        case (AVS_ADDRESS)
            `OFS_STAGE_SEL:  rd_mux = {14'h0000, s_r.stage_sel};
            `OFS_MODE:       rd_mux = {28'h0000000, s_r.mode};
            `OFS_IRQ_STATUS: rd_mux = {31'h00000000, s_r.irq_status};
            `OFS_IRQ_MASK:   rd_mux = {31'h00000000, s_r.irq_mask};
            `OFS_ACC_LO:     rd_mux = acc_view[31:0];
            `OFS_ACC_HI:     rd_mux = acc_view[63:32];
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // next state of the whole block
    logic        wr_go;
    logic [31:0] wm;
    always_comb begin
        s_nxt = s_r;
        wr_go = AVS_WRITE & s_r.ack;
        wm = 32'h00000000;
        // two-flop synchroniser for all fabric pins
        s_nxt.sync1 = {SLICE_RESET_CANDIDATES, SLICE_ENABLE_CANDIDATES,
                       SLICE_CLOCK_CANDIDATES, ACC_SUBTRACT,
                       OPERAND_SIGNED, OPERAND_B, OPERAND_A};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.clk_prev = clk_now;

        // input stage
        if (sc_in.clear) begin
            s_nxt.a_q = '0;
            s_nxt.b_q = '0;
            s_nxt.in_signed = 1'b0;
            s_nxt.in_sub = 1'b0;
        end else if (sc_in.step) begin                        // RULE2
            s_nxt.a_q = a_now;
            s_nxt.b_q = b_now;
            s_nxt.in_signed = s_r.mode[`MODE_DYN_SIGN]
                            ? sgn_now : s_r.mode[`MODE_SIGNED]; // RULE11
            s_nxt.in_sub = s_r.mode[`MODE_DYN_SUB]
                         ? sub_now : s_r.mode[`MODE_SUB];       // RULE12
        end

        // pipeline stage: one signedness for both operands
        if (sc_pl.clear) begin
            s_nxt.prod_q = '0;
            s_nxt.pl_signed = 1'b0;
            s_nxt.pl_sub = 1'b0;
        end else if (sc_pl.step) begin
            s_nxt.prod_q = P_W'(ext(s_r.a_q, s_r.in_signed)
                              * ext(s_r.b_q, s_r.in_signed)); // RULE13
            s_nxt.pl_signed = s_r.in_signed;
            s_nxt.pl_sub = s_r.in_sub;
        end

        // output stage holds the sum; flag lasts a single cycle
        s_nxt.ovf = 1'b0;                                     // RULE8
        if (sc_out.clear) begin
            s_nxt.acc = '0;
        end else if (sc_out.step) begin
            s_nxt.acc = sum[ACC_W-1:0];                       // RULE10
            s_nxt.ovf = ovf_now;                              // RULE14
        end

        // bus slave: one wait cycle, then answer
        s_nxt.ack = (AVS_READ | AVS_WRITE) & ~s_r.ack;
        if (AVS_READ && !s_r.ack) begin
            s_nxt.rdata = rd_mux;
        end
        if (wr_go) begin
            case (AVS_ADDRESS)
                `OFS_STAGE_SEL: begin
                    wm = wmerge({14'h0000, s_r.stage_sel},
                                AVS_WRITEDATA, AVS_BYTEENABLE);
                    s_nxt.stage_sel = wm[`STAGE_SEL_W-1:0];
                end
                `OFS_MODE: begin
                    wm = wmerge({28'h0000000, s_r.mode},
                                AVS_WRITEDATA, AVS_BYTEENABLE);
                    s_nxt.mode = wm[`MODE_W-1:0];
                end
                `OFS_IRQ_STATUS: begin
                    wm = wmerge(32'h00000000, AVS_WRITEDATA,
                                AVS_BYTEENABLE);
                    s_nxt.irq_status = s_r.irq_status & ~wm[`IRQ_W-1:0];
                end
                `OFS_IRQ_MASK: begin
                    wm = wmerge({31'h00000000, s_r.irq_mask},
                                AVS_WRITEDATA, AVS_BYTEENABLE);
                    s_nxt.irq_mask = wm[`IRQ_W-1:0];
                end
                default: begin
                    wm = 32'h00000000;
                end
            endcase
        end
        // a new overflow wins over a clear in the same cycle
        if (s_r.ovf) begin
            s_nxt.irq_status[`IRQ_OVERFLOW] = 1'b1;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_r <= '0;
            s_r.stage_sel <= `STAGE_SEL_RST;
            s_r.mode <= `MODE_RST;
            s_r.irq_status <= `IRQ_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_r.ack;
    assign AVS_READDATA    = s_r.rdata;
    assign ACC_RESULT      = s_r.acc;
    assign OVERFLOW_PULSE  = s_r.ovf;                         // RULE8
    assign IRQ             = |(s_r.irq_status & s_r.irq_mask);
endmodule // dsp_slice_ctl
`default_nettype wire

// [bench/dsp_slice_ctl_asserts.sv]
// checker of bus timing, accumulator steps and overflow pulses
`timescale 1ns/1ps
`default_nettype none
module dsp_slice_ctl_asserts #(
    parameter int OP_W  = 18, // operand width
    parameter int ACC_W = 52  // sum width
) (
    input wire logic             REF_CLK,         // clock
    input wire logic             RST,             // reset
    input wire logic [4:0]       AVS_ADDRESS,     // address
    input wire logic             AVS_READ,        // read
    input wire logic             AVS_WRITE,       // write
    input wire logic [31:0]      AVS_WRITEDATA,   // write data
    input wire logic [31:0]      AVS_READDATA,    // read data
    input wire logic             AVS_WAITREQUEST, // stall
    input wire logic [ACC_W-1:0] ACC_RESULT,      // sum
    input wire logic             OVERFLOW_PULSE,  // pulse
    input wire logic             IRQ              // interrupt
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    logic [3:0]       mode_r;  // mode shadow
    logic             mask_r;  // mask shadow
    logic [ACC_W-1:0] prev_r;  // sum a cycle ago
    logic [ACC_W-1:0] diff;    // last addend
    logic             wr_done; // write lands
    logic             step;    // sum moved, not cleared
    assign wr_done = AVS_WRITE && !AVS_WAITREQUEST;
    assign diff    = ACC_RESULT - prev_r;
    assign step    = ACC_RESULT != prev_r && ACC_RESULT != '0;
    // shadows follow completed writes
    always_ff @(posedge REF_CLK) begin
        prev_r <= ACC_RESULT;
        if (RST) begin
            mode_r <= 4'h0;
            mask_r <= 1'b0;
        end else if (wr_done && AVS_ADDRESS == 5'h04) begin
            mode_r <= AVS_WRITEDATA[3:0];
        end else if (wr_done && AVS_ADDRESS == 5'h0C) begin
            mask_r <= AVS_WRITEDATA[0];
        end
    end
    pulse_one_a: assert property (OVERFLOW_PULSE |=> !OVERFLOW_PULSE)
        else $error("overflow pulse too long");
    pulse_step_a: assert property (OVERFLOW_PULSE |-> ACC_RESULT != prev_r)
        else $error("overflow pulse without sum step");
    acc_spaced_a: assert property (ACC_RESULT != prev_r |=> $stable(ACC_RESULT))
        else $error("sum stepped on two cycles in a row");
    uns_wrap_a: assert property (mode_r == 4'h0 && step |->
        OVERFLOW_PULSE == (ACC_RESULT < prev_r))
        else $error("unsigned wrap flag wrong");
    sgn_wrap_a: assert property (mode_r == 4'h2 && step |->
        OVERFLOW_PULSE == (prev_r[ACC_W-1] == diff[ACC_W-1]
        && ACC_RESULT[ACC_W-1] != prev_r[ACC_W-1]))
        else $error("signed wrap flag wrong");
    wait_once_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST)
        else $error("bus answer late");
    unmapped_a: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS > 5'h14 |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    irq_mask_a: assert property (!mask_r |-> !IRQ)
        else $error("masked interrupt raised");
    cover property (OVERFLOW_PULSE && mode_r == 4'h0);
    cover property (OVERFLOW_PULSE && mode_r == 4'h2);
    cover property ($rose(IRQ));
endmodule // dsp_slice_ctl_asserts
bind dsp_slice_ctl dsp_slice_ctl_asserts #(.OP_W(OP_W), .ACC_W(ACC_W))
    i_dsp_slice_ctl_asserts (.REF_CLK(REF_CLK), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .ACC_RESULT(ACC_RESULT),
    .OVERFLOW_PULSE(OVERFLOW_PULSE), .IRQ(IRQ));
`default_nettype wire

// [bench/fabric_side.sv]
// fabric model: candidate clock, operand padding, pulse counting
`timescale 1ns/1ps
`default_nettype none
module fabric_side #(
    parameter int OP_W = 18, // native width
    parameter int NW   = 8   // narrow width
) (
    input  wire logic            clk,      // system clock
    input  wire logic            run,      // candidate 0 may toggle
    input  wire logic            sgn,      // operands signed
    input  wire logic [NW-1:0]   a_n,      // narrow a
    input  wire logic [NW-1:0]   b_n,      // narrow b
    output logic      [3:0]      clk_cand, // clock candidates
    output logic      [OP_W-1:0] op_a,     // padded a
    output logic      [OP_W-1:0] op_b,     // padded b
    input  wire logic            ovf,      // overflow pulse
    output logic      [7:0]      ext_hi    // upper sum bits
);
    logic [1:0] div; // cycles into a level
    initial begin
        clk_cand = 4'h0;
        div = 2'h0;
        ext_hi = 8'h0;
    end
    // candidate 0 stands still unless run, three cycles a level
    always @(posedge clk) begin
        if (run) begin
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (div == 2'h2) begin
                clk_cand[0] <= ~clk_cand[0];
            end
        end
    end
    // zero fill or sign extension, one signedness for both
    assign op_a = {{(OP_W-NW){sgn & a_n[NW-1]}}, a_n};
    assign op_b = {{(OP_W-NW){sgn & b_n[NW-1]}}, b_n};
    // pulses counted as upper sum bits
    always @(posedge clk) begin
        if (ovf) begin
            ext_hi <= ext_hi + 8'h1;
        end
    end
endmodule // fabric_side
`default_nettype wire

// [bench/dsp_slice_control_and_overflow_test.sv]
// self-checking bench of the slice control and overflow block
`timescale 1ns/1ps
`default_nettype none
module dsp_slice_control_and_overflow_test;
    localparam int OP_W  = 9;  // narrow native width
    localparam int ACC_W = 18; // short sum, wraps fast
    logic             clk, rst, rd, wr, waitreq, sgn, sub, run, ovf, irq;
    logic [4:0]       addr;
    logic [31:0]      wdata, rdata;
    logic [3:0]       clk_c, en_c, rst_c;
    logic [OP_W-1:0]  op_a, op_b;
    logic [7:0]       a_n, b_n, ext_hi;
    logic [ACC_W-1:0] acc;
    int               fails, check_count, cycles;
    dsp_slice_ctl #(.OP_W(OP_W), .ACC_W(ACC_W)) i_dsp_slice_ctl (
        .REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .SLICE_CLOCK_CANDIDATES(clk_c), .SLICE_ENABLE_CANDIDATES(en_c),
        .SLICE_RESET_CANDIDATES(rst_c), .OPERAND_A(op_a), .OPERAND_B(op_b),
        .OPERAND_SIGNED(sgn), .ACC_SUBTRACT(sub), .ACC_RESULT(acc),
        .OVERFLOW_PULSE(ovf), .IRQ(irq));
    fabric_side #(.OP_W(OP_W), .NW(8)) i_fabric_side (.clk(clk),
        .run(run), .sgn(sgn), .a_n(a_n), .b_n(b_n), .clk_cand(clk_c),
        .op_a(op_a), .op_b(op_b), .ovf(ovf), .ext_hi(ext_hi));
    always #2.5 clk = ~clk;
    task automatic summarize();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one access, held until waitrequest is low at an edge
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(string nm, logic [4:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rdata);
    endtask
    task automatic spin(int n);
        @(posedge clk);
        run <= 1'b1;
        repeat (n) @(posedge clk);
        run <= 1'b0;
    endtask
    // reset candidate 0 clears every stage
    task automatic clear();
        @(posedge clk);
        rst_c <= 4'h1;
        spin(30);
        @(posedge clk);
        rst_c <= 4'h0;
        repeat (8) @(posedge clk);
        chk("cleared sum", 32'h0, 32'(acc));
    endtask
    task automatic regs();
        for (int i = 0; i < 8; i++) rd_chk("reset value", 5'(i * 4), 32'h0);
        bus(1'b1, 5'h10, 32'hFFFFFFFF);
        rd_chk("read-only sum", 5'h10, 32'h0);
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        rd_chk("unmapped", 5'h1C, 32'h0);
        bus(1'b1, 5'h00, 32'h1000);
        rd_chk("stage select", 5'h00, 32'h1000);
        @(posedge clk);
        a_n <= 8'h3;
        b_n <= 8'h3;
        spin(60);
        repeat (8) @(posedge clk);
        chk("idle output stage", 32'h0, 32'(acc));
        bus(1'b1, 5'h00, 32'h0);
        $display("test registers done");
    endtask
    // accumulate to the first overflow pulse, then judge the sum
    task automatic wrap(string nm, logic [3:0] m, logic s, logic u,
                        logic [7:0] v, logic [31:0] exp);
        logic [7:0] e0;
        clear();
        bus(1'b1, 5'h04, {28'h0, m});
        @(posedge clk);
        sgn <= s;
        sub <= u;
        a_n <= v;
        b_n <= v;
        run <= 1'b1;
        e0 = ext_hi;
        @(negedge clk);
        while (ovf !== 1'b1) @(negedge clk);
        chk(nm, exp, 32'(acc));
        @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pulse count", 32'(e0) + 32'h1, 32'(ext_hi));
        $display("test %s done", nm);
    endtask
    task automatic irq_test();
        rd_chk("status", 5'h08, 32'h1);
        chk("masked level", 32'h0, 32'(irq));
        bus(1'b1, 5'h0C, 32'h1);
        @(negedge clk);
        chk("unmasked level", 32'h1, 32'(irq));
        bus(1'b1, 5'h08, 32'h1);
        @(negedge clk);
        chk("cleared level", 32'h0, 32'(irq));
        rd_chk("cleared status", 5'h08, 32'h0);
        $display("test interrupt done");
    endtask
    // cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            chk("cycle limit", 32'h0, 32'h1);
            summarize();
        end
    end
    initial begin
        {clk, rd, wr, sgn, sub, run, cycles, fails, check_count} = '0;
        {addr, wdata, rst_c, a_n, b_n} = '0;
        rst = 1'b1;
        en_c = 4'hF;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        regs();
        wrap("unsigned", 4'h0, 1'b0, 1'b0, 8'hFF, 32'(18'(5 * 255 * 255)));
        wrap("signed", 4'h2, 1'b1, 1'b0, 8'h80, 32'h20000);
        wrap("borrow", 4'h7, 1'b0, 1'b1, 8'h01, 32'h3FFFF);
        irq_test();
        summarize();
    end
endmodule // dsp_slice_control_and_overflow_test
`default_nettype wire
